// ---- rscsl_capture.sv ----
// Reset cause flag register
`timescale 1ns/100ps
module rscsl_capture (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic capture,
   input rscsl_pkg::rscsl_cause_s cause,
   output logic [7:0] flags_q
);
   logic [7:0] flags_d;
   always_comb begin
      // R13: bit 0 never set
      flags_d = '0;
      if (cause.low_voltage_flag) begin
         // R6: low-voltage entry
         flags_d[rscsl_pkg::BIT_POR] = flags_q[rscsl_pkg::BIT_POR];
         flags_d[rscsl_pkg::BIT_LVD] = 1'b1;
      end else begin
         // R7: active sources only
         flags_d[rscsl_pkg::BIT_PIN] = cause.pin;
         flags_d[rscsl_pkg::BIT_WD] = cause.wd;
         flags_d[rscsl_pkg::BIT_ILLEGAL_OPCODE_FLAG] = cause.illegal_opcode_flag;
         flags_d[rscsl_pkg::BIT_ILLEGAL_ADDRESS_FLAG] = cause.illegal_address_flag;
         flags_d[rscsl_pkg::BIT_LOC] = cause.clock_loss_flag;
      end
   end
   always_ff @(posedge clock or negedge rst_b) begin
      // R5: power-on value
      if (!rst_b) begin
         flags_q <= rscsl_pkg::FLAGS_POR_VALUE;
      // R2: debug force sets no flag
      end else if (clk_en && capture) begin
         flags_q <= flags_d;
      end
   end
endmodule : rscsl_capture

// ---- rscsl_dbg_host.sv ----
// Debug host model driving the byte-wide background write port
`timescale 1ns/100ps
module rscsl_dbg_host (
   input wire logic clock,
   output logic dbg_wr_en,
   output logic dbg_reg_sel,
   output logic [7:0] dbg_wdata
);
   // ------------------------------------------------------------
   // Idle levels and background write
   // ------------------------------------------------------------
   initial begin
      dbg_wr_en = 1'h0;
      dbg_reg_sel = 1'h0;
      dbg_wdata = 8'h00;
   end
   task automatic bg_write(input logic sel, input logic [7:0] data);
      @(posedge clock);
      #1;
      dbg_reg_sel = sel;
      dbg_wdata = data;
      dbg_wr_en = 1'h1;
      @(posedge clock);
      #1;
      dbg_wr_en = 1'h0;
      dbg_wdata = ~data;
   endtask : bg_write
endmodule : rscsl_dbg_host

// ---- rscsl_pkg.sv ----
// Constants and types for the reset source status logic
//
// Overview of operation
// R1: Read-only flags show last reset source
// R2: Debug forced reset leaves all flags clear
// R3: Bad watchdog write value forces watchdog reset
// R4: 0x55 then 0xAA clears watchdog, flags kept
// R5: Power-on sets bits 7 and 1 only
// R6: Low-voltage sets bit 1, keeps bit 7
// R7: Other resets flag only sources active
// R8: Reset pin low sets bit 6
// R9: Watchdog timeout sets bit 5 when enabled
// R10: Illegal opcode, stop, background set bit 4
// R11: Unimplemented address access sets bit 3
// R12: Clock loss sets bit 2
// R13: Bit 0 always reads zero
// R14: User writes to force register ignored
// R15: Force register always reads 0x00
// R16: Debug host force bit resets device
// R17: Host sets force bit by background write
// R18: Window mode early write forces reset
package rscsl_pkg;
   // ------------------------------------------------------------
   // Register selection and values
   // ------------------------------------------------------------
   localparam logic REG_SEL_FLAGS = 1'h0;
   localparam logic REG_SEL_FORCE = 1'h1;
   localparam logic [7:0] SVC_FIRST = 8'h55;
   localparam logic [7:0] SVC_SECOND = 8'hAA;
   localparam logic [7:0] FORCE_READ_VALUE = 8'h00;
   localparam logic [7:0] FLAGS_POR_VALUE = 8'h82;
   localparam int unsigned BIT_POR = 7;
   localparam int unsigned BIT_PIN = 6;
   localparam int unsigned BIT_WD = 5;
   localparam int unsigned BIT_ILLEGAL_OPCODE_FLAG = 4;
   localparam int unsigned BIT_ILLEGAL_ADDRESS_FLAG = 3;
   localparam int unsigned BIT_LOC = 2;
   localparam int unsigned BIT_LVD = 1;
   localparam int unsigned BIT_FORCE = 0;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 5;
   localparam int unsigned RESET_HOLD_NS = 100;
   localparam int unsigned RESET_HOLD_CYCLES = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned WD_TIMEOUT_CYCLES = 8192;
   localparam int unsigned WD_WINDOW_PCT = 75;
   localparam int unsigned WD_PCT_FULL = 100;
   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic {SEQ_RUN, SEQ_HOLD} rscsl_seq_e;
   typedef struct packed {
      logic pin;
      logic wd;
      logic illegal_opcode_flag;
      logic illegal_address_flag;
      logic clock_loss_flag;
      logic low_voltage_flag;
      logic force_dbg;
   } rscsl_cause_s;
   function automatic logic is_service_value(input logic [7:0] data);
      is_service_value = (data == SVC_FIRST) || (data == SVC_SECOND);
   endfunction : is_service_value
endpackage : rscsl_pkg

// ---- rscsl_top.sv ----
// Reset sequencer, source detection and register access
`timescale 1ns/100ps
module rscsl_top #(
   parameter int unsigned WD_TIMEOUT = rscsl_pkg::WD_TIMEOUT_CYCLES,
   parameter int unsigned HOLD_CYCLES = rscsl_pkg::RESET_HOLD_CYCLES
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic cpu_wr_en,
   input wire logic cpu_rd_en,
   input wire logic cpu_reg_sel,
   input wire logic [7:0] cpu_wdata,
   output logic [7:0] cpu_rdata_q,
   input wire logic dbg_wr_en,
   input wire logic dbg_reg_sel,
   input wire logic [7:0] dbg_wdata,
   input wire logic pin_reset_b,
   input wire logic clock_loss,
   input wire logic lvd_trip,
   input wire logic low_voltage_reset_enable,
   input wire logic watchdog_enable_setting,
   input wire logic watchdog_window_mode,
   input wire logic stop_enable_setting,
   input wire logic background_mode_enable,
   input wire logic opcode_valid,
   input wire logic opcode_unimplemented,
   input wire logic stop_instruction,
   input wire logic background_instruction,
   input wire logic access_valid,
   input wire logic address_unimplemented,
   output logic mcu_reset_b_q,
   output logic [7:0] reset_cause_flags_q
);
   localparam int unsigned HOLD_W = $clog2(HOLD_CYCLES + 1);
   localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(HOLD_CYCLES - 1);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   rscsl_pkg::rscsl_seq_e state_q;
   rscsl_pkg::rscsl_seq_e state_d;
   rscsl_pkg::rscsl_cause_s cause;
   logic [HOLD_W-1:0] hold_q;
   logic [HOLD_W-1:0] hold_d;
   logic [7:0] rd_mux;
   wire run = (state_q == rscsl_pkg::SEQ_RUN);
   rscsl_wd_if wd_if ();
   default clocking @(posedge clock);
   endclocking
   default disable iff (!rst_b);

   // ------------------------------------------------------------
   // Register access decode
   // ------------------------------------------------------------
   wire cpu_wr_flags = cpu_wr_en && (cpu_reg_sel == rscsl_pkg::REG_SEL_FLAGS);
   wire cpu_wr_force = cpu_wr_en && (cpu_reg_sel == rscsl_pkg::REG_SEL_FORCE);
   wire cpu_rd_force = cpu_rd_en && (cpu_reg_sel == rscsl_pkg::REG_SEL_FORCE);
   wire cpu_rd_flags = cpu_rd_en && (cpu_reg_sel == rscsl_pkg::REG_SEL_FLAGS);
   // R14: only the debug port reaches force bit
   wire dbg_wr_force = dbg_wr_en && (dbg_reg_sel == rscsl_pkg::REG_SEL_FORCE);
   // R17: host write sets force bit
   wire force_src = dbg_wr_force && dbg_wdata[rscsl_pkg::BIT_FORCE];
   // R15: force register reads zero
   assign rd_mux = cpu_rd_force ? rscsl_pkg::FORCE_READ_VALUE : reset_cause_flags_q;

   // ------------------------------------------------------------
   // Watchdog hookup
   // ------------------------------------------------------------
   assign wd_if.svc_wr = run && cpu_wr_flags;
   assign wd_if.svc_data = cpu_wdata;
   assign wd_if.wd_enable = watchdog_enable_setting;
   assign wd_if.window_mode = watchdog_window_mode;
   assign wd_if.reinit = !run;

   rscsl_watchdog #(
      .TIMEOUT_CYCLES(WD_TIMEOUT)
   ) u_watchdog (
      .clock(clock),
      .rst_b(rst_b),
      .clk_en(clk_en),
      .wd(wd_if.wd)
   );

   // ------------------------------------------------------------
   // Reset source detection
   // ------------------------------------------------------------
   // R8: external pin level
   wire pin_src = !pin_reset_b;
   // R9: watchdog causes
   wire wd_src = wd_if.timeout || wd_if.bad_write || wd_if.early_write;
   // R10: illegal opcode cases
   wire stop_bad = stop_instruction && !stop_enable_setting;
   wire background_instruction_bad = background_instruction && !background_mode_enable;
   wire illegal_opcode_flag_src = opcode_valid && (opcode_unimplemented || stop_bad || background_instruction_bad);
   // R11: illegal address access
   wire illegal_address_flag_src = access_valid && address_unimplemented;
   // R12: clock loss
   wire loc_src = clock_loss;
   // R6: low-voltage trip when enabled
   wire lvd_src = lvd_trip && low_voltage_reset_enable;
   wire any_src = pin_src || wd_src || illegal_opcode_flag_src || illegal_address_flag_src || loc_src || lvd_src || force_src;
   wire capture = run && any_src;

   assign cause.pin = pin_src;
   assign cause.wd = wd_src;
   assign cause.illegal_opcode_flag = illegal_opcode_flag_src;
   assign cause.illegal_address_flag = illegal_address_flag_src;
   assign cause.clock_loss_flag = loc_src;
   assign cause.low_voltage_flag = lvd_src;
   assign cause.force_dbg = force_src;

   // ------------------------------------------------------------
   // Flag register
   // ------------------------------------------------------------
   // R1: flags fixed at reset entry
   rscsl_capture u_capture (
      .clock(clock),
      .rst_b(rst_b),
      .clk_en(clk_en),
      .capture(capture),
      .cause(cause),
      .flags_q(reset_cause_flags_q)
   );

   // ------------------------------------------------------------
   // Reset sequencer
   // ------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      hold_d = hold_q;
      case (state_q)
         rscsl_pkg::SEQ_RUN: begin
            // R16: any source enters reset
            if (any_src) begin
               state_d = rscsl_pkg::SEQ_HOLD;
               hold_d = HOLD_LAST;
            end
         end
         rscsl_pkg::SEQ_HOLD: begin
            if (hold_q != '0) begin
               hold_d = hold_q - 1'b1;
            end else if (pin_reset_b) begin
               state_d = rscsl_pkg::SEQ_RUN;
            end
         end
         default: begin
            state_d = rscsl_pkg::SEQ_HOLD;
            hold_d = HOLD_LAST;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= rscsl_pkg::SEQ_HOLD;
         hold_q <= HOLD_LAST;
         mcu_reset_b_q <= 1'b0;
      end else if (clk_en) begin
         state_q <= state_d;
         hold_q <= hold_d;
         mcu_reset_b_q <= (state_d == rscsl_pkg::SEQ_RUN);
      end
   end

   // ------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         cpu_rdata_q <= 8'h00;
      end else if (clk_en && cpu_rd_en) begin
         cpu_rdata_q <= rd_mux;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   flags_read_a: assert property (@(posedge clock) disable iff (!rst_b) // R1
      (clk_en && cpu_rd_flags)
      |=> (cpu_rdata_q == $past(reset_cause_flags_q)))
      else $error("flag read returned wrong value");

   force_read_a: assert property (@(posedge clock) disable iff (!rst_b) // R15
      (clk_en && cpu_rd_force)
      |=> (cpu_rdata_q == 8'h00))
      else $error("force register read not zero");

   bit0_zero_a: assert property (@(posedge clock) disable iff (!rst_b) // R13
      !reset_cause_flags_q[0] && !cpu_rdata_q[0])
      else $error("flag bit 0 not zero");

   force_clear_a: assert property (@(posedge clock) disable iff (!rst_b) // R2
      (clk_en && capture && force_src && !pin_src && !wd_src && !illegal_opcode_flag_src
      && !illegal_address_flag_src && !loc_src && !lvd_src) |=> (reset_cause_flags_q == 8'h00))
      else $error("debug forced reset left a flag set");

   bad_write_a: assert property (@(posedge clock) disable iff (!rst_b) // R3
      (clk_en && run && cpu_wr_flags && watchdog_enable_setting
      && !rscsl_pkg::is_service_value(cpu_wdata)) ##1 clk_en
      |=> (!mcu_reset_b_q && reset_cause_flags_q[5]))
      else $error("bad watchdog write did not reset");

   svc_keep_a: assert property (@(posedge clock) disable iff (!rst_b) // R4
      (clk_en && cpu_wr_flags && !capture)
      |=> (reset_cause_flags_q == $past(reset_cause_flags_q)))
      else $error("service write changed flags");

   por_flags_a: assert property (@(posedge clock) // R5
      $rose(rst_b) |-> (reset_cause_flags_q == 8'h82) && !mcu_reset_b_q)
      else $error("power-on flags wrong");

   lvd_flags_a: assert property (@(posedge clock) disable iff (!rst_b) // R6
      (clk_en && capture && lvd_src) |=> (reset_cause_flags_q
      == {$past(reset_cause_flags_q[7]), 5'h00, 1'b1, 1'b0}))
      else $error("low-voltage flags wrong");

   other_flags_a: assert property (@(posedge clock) disable iff (!rst_b) // R7
      (clk_en && capture && !lvd_src) |=> (reset_cause_flags_q == {1'b0,
      $past(pin_src), $past(wd_src), $past(illegal_opcode_flag_src), $past(illegal_address_flag_src),
      $past(loc_src), 2'h0}))
      else $error("source flags wrong");

   pin_flag_a: assert property (@(posedge clock) disable iff (!rst_b) // R8
      (clk_en && run && !pin_reset_b && !lvd_src) |=> reset_cause_flags_q[6])
      else $error("pin reset flag missing");

   illegal_opcode_flag_reset_a: assert property (@(posedge clock) disable iff (!rst_b) // R10
      (clk_en && run && opcode_valid && stop_instruction && !stop_enable_setting
      && !lvd_src) |=> (!mcu_reset_b_q && reset_cause_flags_q[4]))
      else $error("illegal stop did not reset");

   illegal_address_flag_reset_a: assert property (@(posedge clock) disable iff (!rst_b) // R11
      (clk_en && run && illegal_address_flag_src && !lvd_src)
      |=> (!mcu_reset_b_q && reset_cause_flags_q[3]))
      else $error("illegal address did not reset");

   loc_flag_a: assert property (@(posedge clock) disable iff (!rst_b) // R12
      (clk_en && run && clock_loss && !lvd_src)
      |=> reset_cause_flags_q[2])
      else $error("clock loss flag missing");

   force_reset_a: assert property (@(posedge clock) disable iff (!rst_b) // R16
      (clk_en && run && force_src)
      |=> !mcu_reset_b_q)
      else $error("debug force did not reset");

   cpu_force_ign_a: assert property (@(posedge clock) disable iff (!rst_b) // R14
      (clk_en && run && cpu_wr_force && !any_src)
      |=> mcu_reset_b_q)
      else $error("user write to force register acted");

   hold_min_a: assert property (@(posedge clock) disable iff (!rst_b) // R16
      (clk_en && $fell(mcu_reset_b_q))
      |-> !mcu_reset_b_q [*8])
      else $error("reset pulse too short");

   // ------------------------------------------------------------
   // Sequencer, capture and freeze checks
   // ------------------------------------------------------------
   seq_match_a: assert property ( // R16
      mcu_reset_b_q == run)
      else $error("reset output differs from state");

   reset_entry_a: assert property ( // R16
      (clk_en && run && any_src)
      |=> !mcu_reset_b_q)
      else $error("reset source did not reset");

   run_keep_a: assert property ( // R16
      (clk_en && run && !any_src)
      |=> mcu_reset_b_q)
      else $error("reset without a source");

   hold_count_a: assert property ( // R16
      (clk_en && !run && (hold_q != '0))
      |=> !mcu_reset_b_q)
      else $error("reset released before hold ended");

   pin_hold_a: assert property ( // R8
      (clk_en && !run && !pin_reset_b)
      |=> !mcu_reset_b_q)
      else $error("reset released while pin low");

   unimpl_reset_a: assert property ( // R10
      (clk_en && run && opcode_valid && opcode_unimplemented && !lvd_src)
      |=> (!mcu_reset_b_q && reset_cause_flags_q[4]))
      else $error("unimplemented opcode did not reset");

   background_instruction_reset_a: assert property ( // R10
      (clk_en && run && opcode_valid && background_instruction
      && !background_mode_enable && !lvd_src)
      |=> (!mcu_reset_b_q && reset_cause_flags_q[4]))
      else $error("illegal background did not reset");

   wd_flag_a: assert property ( // R9
      (clk_en && run && wd_if.timeout && !lvd_src)
      |=> (!mcu_reset_b_q && reset_cause_flags_q[5]))
      else $error("watchdog timeout flag missing");

   wd_reinit_a: assert property ( // R9
      (clk_en && !run)
      |=> !wd_if.timeout)
      else $error("watchdog timed out during reset");

   capture_once_a: assert property ( // R1
      (clk_en && !run)
      |=> $stable(reset_cause_flags_q))
      else $error("flags changed during reset");

   rdata_hold_a: assert property ( // R1
      !(clk_en && cpu_rd_en)
      |=> $stable(cpu_rdata_q))
      else $error("read data changed without read");

   freeze_state_a: assert property ( // R1
      !clk_en
      |=> ($stable(reset_cause_flags_q) && $stable(mcu_reset_b_q)))
      else $error("state changed while clock disabled");
endmodule : rscsl_top

// ---- rscsl_top_test.sv ----
// Self-checking bench for the reset source status logic
`timescale 1ns/100ps
module rscsl_top_test;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   localparam int unsigned WD_T = 64;
   localparam int unsigned HOLD_T = 10;
   localparam logic [8:0] OP_SRC [0:7] = '{9'h003, 9'h005, 9'h009, 9'h030, 9'h040,
      9'h005, 9'h009, 9'h020};
   localparam logic [7:0] OP_EXP [0:7] = '{8'h10, 8'h10, 8'h10, 8'h08, 8'h04, 8'h00,
      8'h00, 8'h00};
   logic clock = 1'h0;
   logic rst_b = 1'h0;
   logic cpu_wr_en = 1'h0;
   logic cpu_rd_en = 1'h0;
   logic cpu_reg_sel = 1'h0;
   logic [7:0] cpu_wdata = 8'h00;
   logic [8:0] src = 9'h000;
   logic lvd_en = 1'h0;
   logic wd_en = 1'h0;
   logic wd_win = 1'h0;
   logic stop_en = 1'h0;
   logic bg_en = 1'h0;
   logic clk_en = 1'h1;
   logic [7:0] cpu_rdata_q;
   logic [7:0] flags;
   logic mcu_reset_b_q;
   logic dbg_wr_en;
   logic dbg_reg_sel;
   logic [7:0] dbg_wdata;
   int err_total = 0;
   int comparisons = 0;
   int cycles = 0;
   rscsl_top #(.WD_TIMEOUT(WD_T), .HOLD_CYCLES(HOLD_T)) dut_u (
      .clock(clock), .rst_b(rst_b), .clk_en(clk_en), .cpu_wr_en(cpu_wr_en),
      .cpu_rd_en(cpu_rd_en), .cpu_reg_sel(cpu_reg_sel), .cpu_wdata(cpu_wdata),
      .cpu_rdata_q(cpu_rdata_q), .dbg_wr_en(dbg_wr_en), .dbg_reg_sel(dbg_reg_sel),
      .dbg_wdata(dbg_wdata), .pin_reset_b(~src[8]), .clock_loss(src[6]),
      .lvd_trip(src[7]), .low_voltage_reset_enable(lvd_en),
      .watchdog_enable_setting(wd_en), .watchdog_window_mode(wd_win),
      .stop_enable_setting(stop_en), .background_mode_enable(bg_en),
      .opcode_valid(src[0]), .opcode_unimplemented(src[1]), .stop_instruction(src[2]),
      .background_instruction(src[3]), .access_valid(src[4]),
      .address_unimplemented(src[5]), .mcu_reset_b_q(mcu_reset_b_q),
      .reset_cause_flags_q(flags));
   rscsl_dbg_host host_u (.clock(clock), .dbg_wr_en(dbg_wr_en), .dbg_reg_sel(dbg_reg_sel),
      .dbg_wdata(dbg_wdata));
   // ------------------------------------------------------------
   // Clock, timeout and closing report
   // ------------------------------------------------------------
   initial begin
      forever #2.5 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      $display("errors %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : report_and_stop
   // ------------------------------------------------------------
   // Shared helpers
   // ------------------------------------------------------------
   task automatic tick();
      @(posedge clock);
      #1;
   endtask : tick
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_byte
   task automatic chk_bit(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: level %h expected %h", $time, got, exp);
      end
   endtask : chk_bit
   task automatic read_reg(input logic sel, output logic [7:0] data);
      cpu_reg_sel = sel;
      cpu_rd_en = 1'h1;
      tick();
      data = cpu_rdata_q;
      cpu_rd_en = 1'h0;
      tick();
   endtask : read_reg
   task automatic write_reg(input logic sel, input logic [7:0] data);
      cpu_reg_sel = sel;
      cpu_wdata = data;
      cpu_wr_en = 1'h1;
      tick();
      cpu_wr_en = 1'h0;
      cpu_wdata = ~data;
      tick();
   endtask : write_reg
   task automatic service_pair();
      cpu_reg_sel = 1'h0;
      cpu_wdata = rscsl_pkg::SVC_FIRST;
      cpu_wr_en = 1'h1;
      tick();
      cpu_wdata = rscsl_pkg::SVC_SECOND;
      tick();
      cpu_wr_en = 1'h0;
      tick();
   endtask : service_pair
   task automatic wait_run();
      for (int n = 0; n < 300 && mcu_reset_b_q !== 1'h1; n++) tick();
      chk_bit(mcu_reset_b_q, 1'h1);
   endtask : wait_run
   task automatic stay_run(input int n);
      logic low;
      low = 1'h0;
      repeat (n) begin
         tick();
         if (mcu_reset_b_q !== 1'h1) low = 1'h1;
      end
      chk_bit(low, 1'h0);
   endtask : stay_run
   task automatic expect_reset(input logic [7:0] exp, input int bound);
      logic [7:0] r;
      for (int n = 0; n < bound && mcu_reset_b_q !== 1'h0; n++) tick();
      chk_bit(mcu_reset_b_q, 1'h0);
      chk_byte(flags, exp);
      src = 9'h000;
      wait_run();
      read_reg(1'h0, r);
      chk_byte(r, exp);
   endtask : expect_reset
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_power_on();
      logic [7:0] r;
      repeat (16) tick();
      chk_bit(mcu_reset_b_q, 1'h0);
      chk_byte(flags, 8'h82);
      rst_b = 1'h1;
      wait_run();
      read_reg(1'h0, r);
      chk_byte(r, 8'h82);
   endtask : t_power_on
   task automatic t_user_writes();
      logic [7:0] r;
      write_reg(1'h0, 8'hFF);
      write_reg(1'h0, 8'h12);
      stay_run(10);
      read_reg(1'h0, r);
      chk_byte(r, 8'h82);
      write_reg(1'h1, 8'h01);
      stay_run(10);
      read_reg(1'h1, r);
      chk_byte(r, 8'h00);
   endtask : t_user_writes
   task automatic t_freeze();
      clk_en = 1'h0;
      src = 9'h100;
      stay_run(4);
      src = 9'h000;
      clk_en = 1'h1;
      stay_run(3);
   endtask : t_freeze
   task automatic t_low_voltage();
      src = 9'h080;
      stay_run(5);
      lvd_en = 1'h1;
      expect_reset(8'h82, 4);
   endtask : t_low_voltage
   task automatic t_debug_force();
      host_u.bg_write(1'h1, 8'hFE);
      stay_run(5);
      host_u.bg_write(1'h1, 8'h01);
      expect_reset(8'h00, 3);
   endtask : t_debug_force
   task automatic t_pin_then_lvd();
      src = 9'h100;
      repeat (3) tick();
      expect_reset(8'h40, 2);
      src = 9'h080;
      expect_reset(8'h02, 4);
   endtask : t_pin_then_lvd
   task automatic t_fault_sources();
      for (int i = 0; i < 8; i++) begin
         stop_en = (i >= 5);
         bg_en = (i >= 5);
         src = OP_SRC[i];
         if (OP_EXP[i] == 8'h00) begin
            stay_run(5);
            src = 9'h000;
         end else begin
            expect_reset(OP_EXP[i], 4);
         end
      end
   endtask : t_fault_sources
   task automatic t_watchdog();
      logic [7:0] r;
      wd_en = 1'h1;
      repeat (6) begin
         stay_run(30);
         service_pair();
      end
      read_reg(1'h0, r);
      chk_byte(r, 8'h04);
      write_reg(1'h0, 8'h12);
      expect_reset(8'h20, 3);
      expect_reset(8'h20, WD_T + 5);
   endtask : t_watchdog
   task automatic t_window();
      wd_win = 1'h1;
      stay_run(50);
      service_pair();
      stay_run(20);
      write_reg(1'h0, rscsl_pkg::SVC_FIRST);
      expect_reset(8'h20, 3);
      wd_en = 1'h0;
      wd_win = 1'h0;
   endtask : t_window
   task automatic t_second_power_on();
      rst_b = 1'h0;
      tick();
      chk_byte(flags, 8'h82);
      rst_b = 1'h1;
      wait_run();
   endtask : t_second_power_on
   initial begin
      t_power_on();
      t_user_writes();
      t_freeze();
      t_low_voltage();
      t_debug_force();
      t_pin_then_lvd();
      t_fault_sources();
      t_watchdog();
      t_window();
      t_second_power_on();
      report_and_stop();
   end
endmodule : rscsl_top_test

// ---- rscsl_watchdog.sv ----
// Watchdog counter with service sequence and window check
`timescale 1ns/100ps
module rscsl_watchdog #(
   parameter int unsigned TIMEOUT_CYCLES = rscsl_pkg::WD_TIMEOUT_CYCLES
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic clk_en,
   rscsl_wd_if.wd wd
);
   localparam int unsigned CNT_W = $clog2(TIMEOUT_CYCLES) + 1;
   localparam logic [CNT_W-1:0] LAST = CNT_W'(TIMEOUT_CYCLES - 1);
   localparam logic [CNT_W-1:0] OPEN =
      CNT_W'(TIMEOUT_CYCLES * rscsl_pkg::WD_WINDOW_PCT / rscsl_pkg::WD_PCT_FULL);
   logic [CNT_W-1:0] count_q;
   logic [CNT_W-1:0] count_d;
   logic armed_q;
   logic armed_d;
   logic timeout_q;
   logic bad_q;
   logic early_q;
   wire first_wr = wd.svc_wr && (wd.svc_data == rscsl_pkg::SVC_FIRST);
   wire second_wr = wd.svc_wr && (wd.svc_data == rscsl_pkg::SVC_SECOND);
   // R3: bad value check
   wire bad_wr = wd.svc_wr && wd.wd_enable && !rscsl_pkg::is_service_value(wd.svc_data);
   // R18: early write check
   wire early_wr = wd.svc_wr && wd.wd_enable && wd.window_mode && (count_q < OPEN);
   // R4: pair clears counter
   wire serviced = second_wr && armed_q && !early_wr;
   // R9: timeout only when enabled
   wire expire = wd.wd_enable && (count_q == LAST);
   assign count_d = (wd.reinit || !wd.wd_enable || serviced || expire) ? '0 : count_q + 1'b1;
   assign armed_d = wd.reinit ? 1'b0 : first_wr ? 1'b1 : wd.svc_wr ? 1'b0 : armed_q;
   assign wd.timeout = timeout_q;
   assign wd.bad_write = bad_q;
   assign wd.early_write = early_q;
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         count_q <= '0;
         armed_q <= 1'b0;
         timeout_q <= 1'b0;
         bad_q <= 1'b0;
         early_q <= 1'b0;
      end else if (clk_en) begin
         count_q <= count_d;
         armed_q <= armed_d;
         timeout_q <= expire && !wd.reinit;
         bad_q <= bad_wr && !wd.reinit;
         early_q <= early_wr && !wd.reinit;
      end
   end
   svc_clear_a: assert property (@(posedge clock) disable iff (!rst_b) // R4
      (clk_en && serviced && !wd.reinit) |=> (count_q == '0))
      else $error("service pair did not clear watchdog");
   wd_suppress_a: assert property (@(posedge clock) disable iff (!rst_b) // R9
      (clk_en && !wd.wd_enable) |=> !timeout_q)
      else $error("watchdog timed out while disabled");
   window_early_a: assert property (@(posedge clock) disable iff (!rst_b) // R18
      (clk_en && !wd.reinit && wd.svc_wr && wd.wd_enable && wd.window_mode
      && (count_q < OPEN)) |=> early_q)
      else $error("early write in window mode not caught");
endmodule : rscsl_watchdog

// ---- rscsl_wd_if.sv ----
// Signals between the sequencer and the watchdog
`timescale 1ns/100ps
interface rscsl_wd_if;
   logic svc_wr;
   logic [7:0] svc_data;
   logic wd_enable;
   logic window_mode;
   logic reinit;
   logic timeout;
   logic bad_write;
   logic early_write;
   modport wd (input svc_wr, svc_data, wd_enable, window_mode, reinit,
      output timeout, bad_write, early_write);
   modport ctl (output svc_wr, svc_data, wd_enable, window_mode, reinit,
      input timeout, bad_write, early_write);
endinterface : rscsl_wd_if
